// file: uflp_cfg.svh
// Register map, field positions, reset values and timing counts of the serial unit.
`ifndef UFLP_CFG_SVH
`define UFLP_CFG_SVH

`define UFLP_OFS_CTRL1     8'h00
`define UFLP_OFS_CTRL2     8'h04
`define UFLP_OFS_STATUS    8'h08
`define UFLP_OFS_BAUD_DIV  8'h0c
`define UFLP_OFS_RX_BUF    8'h10
`define UFLP_OFS_TX_BUF    8'h14
`define UFLP_OFS_POWER     8'h18
`define UFLP_OFS_IRQ_STAT  8'h1c
`define UFLP_OFS_IRQ_MASK  8'h20

`define UFLP_CR1_TX_EN     7
`define UFLP_CR1_RX_EN     6
`define UFLP_CR1_STOP2     5
`define UFLP_CR1_EVEN      4
`define UFLP_CR1_PAR_ON    3
`define UFLP_CR1_IRDA      2
`define UFLP_CR1_BRG       1
`define UFLP_CR2_RT_LSB    3
`define UFLP_CR2_NOISE_LSB 1
`define UFLP_CR2_RX_STOP2  0

`define UFLP_SR_PARITY_ERROR_FLAG       7
`define UFLP_SR_FRAMING_ERROR_FLAG       6
`define UFLP_SR_OVERRUN_ERROR_FLAG       5
`define UFLP_SR_RBSY       3
`define UFLP_SR_RXFULL     2
`define UFLP_SR_TBSY       1
`define UFLP_SR_TXFULL     0

`define UFLP_IRQ_TX        0
`define UFLP_IRQ_RX        1
`define UFLP_IRQ_ERR       2

`define UFLP_CTRL1_RST     8'h00
`define UFLP_CTRL2_RST     8'h00
`define UFLP_DIV_RST       8'h00
`define UFLP_RT_BASE       5'h10
`define UFLP_RT_SEL_MAX    3'h4
`define UFLP_IRDA_PULSE    5'h03

`endif

// file: uflp_pkg.sv
// Types shared by the serial unit modules.
package uflp_pkg;

  typedef enum logic [2:0] {
    FR_IDLE   = 3'b000,
    FR_START  = 3'b001,
    FR_DATA   = 3'b010,
    FR_PARITY = 3'b011,
    FR_STOP1  = 3'b100,
    FR_STOP2  = 3'b101
  } uflp_frame_t;

endpackage

// file: uflp_tick_if.sv
// Bit-timing tick shared between the baud generator and the frame engines.
`timescale 1ns/10ps
interface uflp_tick_if;
  logic       rt_tick;
  logic [4:0] rt_len;

  modport gen (output rt_tick, output rt_len);
  modport use_side (input rt_tick, input rt_len);
endinterface

// file: uflp_baud_gen.sv
// Baud generator: base clock select and divisor give the RT tick; the RT count select gives the RT length.
`timescale 1ns/10ps
`include "uflp_cfg.svh"
module uflp_baud_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             base_sel,
  input  wire logic             ext_tick,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic [2:0]       rt_sel,
  uflp_tick_if.gen              tick
);
  logic [DIV_W-1:0] div_cnt_ff;
  logic             rt_tick_ff;
  logic             base_tick;

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("DIV_W out of range");
  end

  assign base_tick = base_sel ? ext_tick : 1'b1;
  assign tick.rt_tick = rt_tick_ff;
  assign tick.rt_len = (rt_sel <= `UFLP_RT_SEL_MAX) ?
                       (`UFLP_RT_BASE - {2'b00, rt_sel}) : `UFLP_RT_BASE;

  always_ff @(posedge core_clk)
  begin
    if (rst || !run) begin
      div_cnt_ff <= '0;
      rt_tick_ff <= 1'b0;
    end else if (base_tick) begin
      rt_tick_ff <= (div_cnt_ff == divisor);
      div_cnt_ff <= (div_cnt_ff == divisor) ? '0 : div_cnt_ff + 1'b1;
    end else begin
      rt_tick_ff <= 1'b0;
    end
  end
endmodule // uflp_baud_gen

// file: uflp_tx.sv
// Transmit frame engine with parity, stop length and infrared encoding.
`timescale 1ns/10ps
`include "uflp_cfg.svh"
module uflp_tx (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       run,
  uflp_tick_if.use_side   tick,
  input  wire logic       parity_on,
  input  wire logic       even,
  input  wire logic       stop2,
  input  wire logic       irda,
  input  wire logic       load_valid,
  input  wire logic [7:0] load_data,
  output logic            load_taken,
  output logic            busy,
  output logic            line
);
  uflp_pkg::uflp_frame_t state_ff;
  logic [7:0]            shift_ff;
  logic [2:0]            bit_ff;
  logic [4:0]            rt_cnt_ff;
  logic                  par_ff;
  logic                  line_ff;
  logic                  level;
  logic                  bit_end;

  assign load_taken = run && (state_ff == uflp_pkg::FR_IDLE) && load_valid;
  assign busy = (state_ff != uflp_pkg::FR_IDLE);
  assign line = line_ff;
  assign bit_end = tick.rt_tick && (rt_cnt_ff == tick.rt_len - 5'h01);

  always_comb
  begin
    unique case (state_ff)
      uflp_pkg::FR_IDLE:   level = 1'b1;
      uflp_pkg::FR_START:  level = 1'b0;
      uflp_pkg::FR_DATA:   level = shift_ff[0];
      uflp_pkg::FR_PARITY: level = par_ff;
      uflp_pkg::FR_STOP1:  level = 1'b1;
      uflp_pkg::FR_STOP2:  level = 1'b1;
      default:             level = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || !run) begin
      state_ff  <= uflp_pkg::FR_IDLE;
      shift_ff  <= 8'h00;
      bit_ff    <= 3'h0;
      rt_cnt_ff <= 5'h00;
      par_ff    <= 1'b0;
    end else if (load_taken) begin
      state_ff  <= uflp_pkg::FR_START;
      shift_ff  <= load_data;
      bit_ff    <= 3'h0;
      rt_cnt_ff <= 5'h00;
      par_ff    <= even ? ^load_data : ~^load_data;
    end else if (busy && tick.rt_tick) begin
      rt_cnt_ff <= bit_end ? 5'h00 : rt_cnt_ff + 5'h01;
      if (bit_end) begin
        unique case (state_ff)
          uflp_pkg::FR_START: state_ff <= uflp_pkg::FR_DATA;
          uflp_pkg::FR_DATA:
          begin
            shift_ff <= {1'b0, shift_ff[7:1]};
            bit_ff   <= bit_ff + 3'h1;
            if (bit_ff == 3'h7)
            begin
              state_ff <= parity_on ? uflp_pkg::FR_PARITY : uflp_pkg::FR_STOP1;
            end
          end
          uflp_pkg::FR_PARITY: state_ff <= uflp_pkg::FR_STOP1;
          uflp_pkg::FR_STOP1:  state_ff <= stop2 ? uflp_pkg::FR_STOP2 : uflp_pkg::FR_IDLE;
          uflp_pkg::FR_STOP2:  state_ff <= uflp_pkg::FR_IDLE;
          default:             state_ff <= uflp_pkg::FR_IDLE;
        endcase
      end
    end
  end

  // Infrared output: a short high pulse at the start of each low bit, idle low.
  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      line_ff <= 1'b1;
    end else if (irda) begin
      line_ff <= busy && !level && (rt_cnt_ff < `UFLP_IRDA_PULSE);
    end else begin
      line_ff <= level;
    end
  end
endmodule // uflp_tx

// file: uflp_top.sv
// Serial unit top: AHB-Lite registers, receiver, low-power handling and pin control.
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "uflp_cfg.svh"
module uflp_top #(
  parameter int HADDR_W = 32
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               hsel,
  input  wire logic [HADDR_W-1:0] haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  input  wire logic               stop_mode,
  input  wire logic               idle_lowpower_mode,
  input  wire logic               sleep_lowpower_mode,
  input  wire logic               sys_out_en,
  input  wire logic               brg_ext_tick,
  input  wire logic               serial_in_pin,
  output logic                    serial_out_pin,
  output logic                    serial_out_oe_n,
  output logic                    irq
);
  if (HADDR_W < 8) begin : g_chk
    $error("HADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  ctrl1_ff;
  logic [7:0]  ctrl2_ff;
  logic [7:0]  div_ff;
  logic        unit_clock_gate_ff;
  logic [2:0]  irq_stat_ff;
  logic [2:0]  irq_mask_ff;
  logic [7:0]  tx_buf_ff;
  logic        tx_full_flag_ff;
  logic [7:0]  rx_buf_ff;
  logic        rx_full_flag_ff;
  logic        parity_error_flag_ff;
  logic        framing_error_flag_ff;
  logic        overrun_error_flag_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        irq_ff;
  logic        pin_ff;
  logic        oe_n_ff;

  logic        lowpower;
  logic        addr_ok;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [7:0]  wd;
  logic [7:0]  rd_mux;
  logic        rd_rxbuf;
  logic        tx_en;
  logic        rx_en;
  logic        tbsy;
  logic        rbsy;
  logic        tx_quiet;
  logic        rx_quiet;
  logic        all_quiet;
  logic        tx_taken;
  logic        tx_line;
  logic        overrun_evt;
  logic [2:0]  irq_evt;

  assign lowpower = stop_mode || idle_lowpower_mode || sleep_lowpower_mode;
  assign tx_en = ctrl1_ff[`UFLP_CR1_TX_EN];
  assign rx_en = ctrl1_ff[`UFLP_CR1_RX_EN];
  assign tx_quiet = !tx_en && !tbsy;
  assign rx_quiet = !rx_en && !rbsy;
  assign all_quiet = tx_quiet && rx_quiet;

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign addr_ok = hsel && hready && htrans[1];
  assign rd_en = addr_ok && !hwrite;
  assign rd_addr = haddr[7:0];
  assign wd = hwdata[7:0];
  assign rd_rxbuf = rd_en && (rd_addr == `UFLP_OFS_RX_BUF);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  always_comb
  begin
    unique case (rd_addr)
      `UFLP_OFS_CTRL1:    rd_mux = ctrl1_ff;
      `UFLP_OFS_CTRL2:    rd_mux = ctrl2_ff;
      `UFLP_OFS_STATUS:   rd_mux = {parity_error_flag_ff, framing_error_flag_ff,
                                    overrun_error_flag_ff, 1'b0, rbsy, rx_full_flag_ff,
                                    tbsy, tx_full_flag_ff};
      `UFLP_OFS_BAUD_DIV: rd_mux = div_ff;
      `UFLP_OFS_RX_BUF:   rd_mux = rx_buf_ff;
      `UFLP_OFS_POWER:    rd_mux = {7'h00, unit_clock_gate_ff};
      `UFLP_OFS_IRQ_STAT: rd_mux = {5'h00, irq_stat_ff};
      `UFLP_OFS_IRQ_MASK: rd_mux = {5'h00, irq_mask_ff};
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      hrdata_ff <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // Control registers with write protection; low-power entry clears the CTRL1 enable bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      ctrl1_ff <= `UFLP_CTRL1_RST;
    end else begin
      if (wr_pend_ff && wr_addr_ff == `UFLP_OFS_CTRL1 && unit_clock_gate_ff) begin
        ctrl1_ff[`UFLP_CR1_TX_EN] <= wd[`UFLP_CR1_TX_EN];
        ctrl1_ff[`UFLP_CR1_RX_EN] <= wd[`UFLP_CR1_RX_EN];
        if (tx_quiet) begin
          ctrl1_ff[`UFLP_CR1_STOP2] <= wd[`UFLP_CR1_STOP2];
          ctrl1_ff[`UFLP_CR1_IRDA]  <= wd[`UFLP_CR1_IRDA];
        end
        if (all_quiet) begin
          ctrl1_ff[`UFLP_CR1_EVEN]   <= wd[`UFLP_CR1_EVEN];
          ctrl1_ff[`UFLP_CR1_PAR_ON] <= wd[`UFLP_CR1_PAR_ON];
          ctrl1_ff[`UFLP_CR1_BRG]    <= wd[`UFLP_CR1_BRG];
        end
      end
      if (lowpower) begin
        ctrl1_ff[`UFLP_CR1_TX_EN] <= 1'b0;
        ctrl1_ff[`UFLP_CR1_RX_EN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      ctrl2_ff <= `UFLP_CTRL2_RST;
    end else if (wr_pend_ff && wr_addr_ff == `UFLP_OFS_CTRL2 && unit_clock_gate_ff) begin
      if (all_quiet) begin
        ctrl2_ff[`UFLP_CR2_RT_LSB +: 3] <= wd[`UFLP_CR2_RT_LSB +: 3];
      end
      if (rx_quiet) begin
        ctrl2_ff[`UFLP_CR2_NOISE_LSB +: 2] <= wd[`UFLP_CR2_NOISE_LSB +: 2];
        ctrl2_ff[`UFLP_CR2_RX_STOP2]       <= wd[`UFLP_CR2_RX_STOP2];
      end
    end
  end

  // The divisor is left untouched by low-power entry.
  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      div_ff <= `UFLP_DIV_RST;
    end else if (wr_pend_ff && wr_addr_ff == `UFLP_OFS_BAUD_DIV && unit_clock_gate_ff) begin
      div_ff <= wd;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      unit_clock_gate_ff <= 1'b0;
      irq_mask_ff        <= 3'h0;
    end else begin
      if (wr_pend_ff && wr_addr_ff == `UFLP_OFS_POWER) begin
        unit_clock_gate_ff <= wd[0];
      end
      if (wr_pend_ff && wr_addr_ff == `UFLP_OFS_IRQ_MASK) begin
        irq_mask_ff <= wd[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Baud generator and transmitter
  // ----------------------------------------------------------------
  uflp_tick_if tick_bus ();

  uflp_baud_gen #(
    .DIV_W (8)
  ) u_baud (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (unit_clock_gate_ff && !lowpower),
    .base_sel (ctrl1_ff[`UFLP_CR1_BRG]),
    .ext_tick (brg_ext_tick),
    .divisor  (div_ff),
    .rt_sel   (ctrl2_ff[`UFLP_CR2_RT_LSB +: 3]),
    .tick     (tick_bus.gen)
  );

  uflp_tx u_tx (
    .core_clk   (core_clk),
    .rst        (rst),
    .run        (unit_clock_gate_ff && !lowpower && tx_en),
    .tick       (tick_bus.use_side),
    .parity_on  (ctrl1_ff[`UFLP_CR1_PAR_ON]),
    .even       (ctrl1_ff[`UFLP_CR1_EVEN]),
    .stop2      (ctrl1_ff[`UFLP_CR1_STOP2]),
    .irda       (ctrl1_ff[`UFLP_CR1_IRDA]),
    .load_valid (tx_full_flag_ff),
    .load_data  (tx_buf_ff),
    .load_taken (tx_taken),
    .busy       (tbsy),
    .line       (tx_line)
  );

  always_ff @(posedge core_clk)
  begin
    if (rst || lowpower) begin
      tx_full_flag_ff <= 1'b0;
      tx_buf_ff       <= 8'h00;
    end else begin
      if (tx_taken) begin
        tx_full_flag_ff <= 1'b0;
      end
      if (wr_pend_ff && wr_addr_ff == `UFLP_OFS_TX_BUF && unit_clock_gate_ff && tx_en) begin
        tx_buf_ff       <= wd;
        tx_full_flag_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic                  rx_meta_ff;
  logic                  rx_sync_ff;
  logic                  rx_prev_ff;
  uflp_pkg::uflp_frame_t rx_state_ff;
  logic [4:0]            rx_cnt_ff;
  logic [2:0]            rx_bit_ff;
  logic [7:0]            rx_shift_ff;
  logic                  rx_parity_error_flag_ff;
  logic                  rx_framing_error_flag_ff;
  logic                  rx_done_ff;
  logic                  rx_run;
  logic [4:0]            rx_target;
  logic                  rx_sample;

  assign rx_run = unit_clock_gate_ff && !lowpower && rx_en;
  assign rbsy = (rx_state_ff != uflp_pkg::FR_IDLE);
  assign rx_target = (rx_state_ff == uflp_pkg::FR_START) ?
                     {1'b0, tick_bus.rt_len[4:1]} : tick_bus.rt_len - 5'h01;
  assign rx_sample = tick_bus.rt_tick && (rx_cnt_ff == rx_target);

  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= serial_in_pin;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || !rx_run) begin
      rx_state_ff <= uflp_pkg::FR_IDLE;
      rx_cnt_ff   <= 5'h00;
      rx_bit_ff   <= 3'h0;
      rx_shift_ff <= 8'h00;
      rx_parity_error_flag_ff  <= 1'b0;
      rx_framing_error_flag_ff  <= 1'b0;
      rx_done_ff  <= 1'b0;
    end else begin
      rx_done_ff <= 1'b0;
      if (!rbsy) begin
        rx_cnt_ff <= 5'h00;
        if (rx_prev_ff && !rx_sync_ff) begin
          rx_state_ff <= uflp_pkg::FR_START;
          rx_parity_error_flag_ff  <= 1'b0;
          rx_framing_error_flag_ff  <= 1'b0;
          rx_bit_ff   <= 3'h0;
        end
      end else if (rx_sample) begin
        rx_cnt_ff <= 5'h00;
        unique case (rx_state_ff)
          uflp_pkg::FR_START:
            rx_state_ff <= rx_sync_ff ? uflp_pkg::FR_IDLE : uflp_pkg::FR_DATA;
          uflp_pkg::FR_DATA:
          begin
            rx_shift_ff <= {rx_sync_ff, rx_shift_ff[7:1]};
            rx_bit_ff   <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == 3'h7)
            begin
              rx_state_ff <= ctrl1_ff[`UFLP_CR1_PAR_ON] ? uflp_pkg::FR_PARITY
                                                        : uflp_pkg::FR_STOP1;
            end
          end
          uflp_pkg::FR_PARITY:
          begin
            rx_parity_error_flag_ff  <= rx_sync_ff != (ctrl1_ff[`UFLP_CR1_EVEN] ? ^rx_shift_ff
                                                                   : ~^rx_shift_ff);
            rx_state_ff <= uflp_pkg::FR_STOP1;
          end
          uflp_pkg::FR_STOP1:
          begin
            rx_framing_error_flag_ff <= !rx_sync_ff;
            if (ctrl2_ff[`UFLP_CR2_RX_STOP2]) begin
              rx_state_ff <= uflp_pkg::FR_STOP2;
            end else begin
              rx_state_ff <= uflp_pkg::FR_IDLE;
              rx_done_ff  <= 1'b1;
            end
          end
          uflp_pkg::FR_STOP2:
          begin
            rx_framing_error_flag_ff  <= rx_framing_error_flag_ff || !rx_sync_ff;
            rx_state_ff <= uflp_pkg::FR_IDLE;
            rx_done_ff  <= 1'b1;
          end
          default: rx_state_ff <= uflp_pkg::FR_IDLE;
        endcase
      end else if (tick_bus.rt_tick) begin
        rx_cnt_ff <= rx_cnt_ff + 5'h01;
      end
    end
  end

  // Reading the receive buffer clears its flags; a new frame in that same cycle wins.
  assign overrun_evt = rx_done_ff && rx_full_flag_ff && !rd_rxbuf;

  always_ff @(posedge core_clk)
  begin
    if (rst || lowpower) begin
      rx_buf_ff             <= 8'h00;
      rx_full_flag_ff       <= 1'b0;
      parity_error_flag_ff  <= 1'b0;
      framing_error_flag_ff <= 1'b0;
      overrun_error_flag_ff <= 1'b0;
    end else begin
      if (rd_rxbuf) begin
        rx_full_flag_ff       <= 1'b0;
        parity_error_flag_ff  <= 1'b0;
        framing_error_flag_ff <= 1'b0;
        overrun_error_flag_ff <= 1'b0;
      end
      if (overrun_evt) begin
        overrun_error_flag_ff <= 1'b1;
      end else if (rx_done_ff) begin
        rx_buf_ff             <= rx_shift_ff;
        rx_full_flag_ff       <= 1'b1;
        parity_error_flag_ff  <= rx_parity_error_flag_ff;
        framing_error_flag_ff <= rx_framing_error_flag_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  assign irq_evt = {rx_done_ff && (rx_parity_error_flag_ff || rx_framing_error_flag_ff || overrun_evt),
                    rx_done_ff, tx_taken};

  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      irq_stat_ff <= 3'h0;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((wr_pend_ff && wr_addr_ff == `UFLP_OFS_IRQ_STAT) ?
                                      wd[2:0] : 3'h0)) | irq_evt;
      irq_ff      <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // Transmit pin control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst) begin
      pin_ff  <= 1'b1;
      oe_n_ff <= 1'b0;
    end else if (stop_mode) begin
      pin_ff  <= sys_out_en && !ctrl1_ff[`UFLP_CR1_IRDA];
      oe_n_ff <= !sys_out_en;
    end else if (idle_lowpower_mode || sleep_lowpower_mode || !unit_clock_gate_ff) begin
      pin_ff  <= !ctrl1_ff[`UFLP_CR1_IRDA];
      oe_n_ff <= 1'b0;
    end else begin
      pin_ff  <= tx_line;
      oe_n_ff <= 1'b0;
    end
  end

  assign serial_out_pin = pin_ff;
  assign serial_out_oe_n = oe_n_ff;

endmodule // uflp_top

// file: uflp_top_props.sv
// Concurrent checks on the ports of the serial unit top.
`timescale 1ns/10ps
module uflp_top_props (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        stop_mode,
  input wire logic        idle_lowpower_mode,
  input wire logic        sleep_lowpower_mode,
  input wire logic        sys_out_en,
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe_n,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic rd_req = hsel && hready && htrans[1] && !hwrite;

  AST_HREADY: assert property (hreadyout) else $error("wait state inserted");
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_RD_UPPER: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_RD_HOLD: assert property (!rd_req |=> $stable(hrdata)) else $error("read data moved");
  AST_RST_OUT: assert property ($fell(rst) |-> serial_out_pin && !serial_out_oe_n && !irq)
    else $error("outputs wrong after reset");
  AST_IDLE_OE: assert property (idle_lowpower_mode && !stop_mode |=> !serial_out_oe_n)
    else $error("pin not driven in idle");
  AST_SLEEP_OE: assert property (sleep_lowpower_mode && !stop_mode |=> !serial_out_oe_n)
    else $error("pin not driven in sleep");
  AST_STOP_HIZ: assert property (stop_mode && !sys_out_en [*2] |=> serial_out_oe_n)
    else $error("pin driven in stop without enable");
  AST_STOP_DRV: assert property (stop_mode && sys_out_en |=> !serial_out_oe_n)
    else $error("pin floating in stop with enable");
  cover property (rd_req);
  cover property ($rose(irq));
  cover property (stop_mode && sys_out_en);
endmodule // uflp_top_props

bind uflp_top uflp_top_props i_props (.core_clk, .rst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hrdata, .hresp, .stop_mode, .idle_lowpower_mode, .sleep_lowpower_mode,
  .sys_out_en, .serial_out_pin, .serial_out_oe_n, .irq);

// file: uflp_remote_model.sv
// Remote serial transceiver: samples transmitted frames and sends bytes back.
`timescale 1ns/10ps
module uflp_remote_model #(
  parameter int BIT_CYC = 12
) (
  input  wire logic core_clk,
  input  wire logic serial_out_pin,
  output logic      serial_in_pin
);
  logic [11:0] frame_q;
  int          n_frames = 0;
  initial serial_in_pin = 1'b1;
  always
  begin
    @(negedge serial_out_pin);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < 12; i++)
    begin
      frame_q[i] = serial_out_pin;
      repeat (BIT_CYC) @(posedge core_clk);
    end
    n_frames++;
  end
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      serial_in_pin <= f[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
  endtask
endmodule // uflp_remote_model

// file: test_uflp_top.sv
// Testbench of the serial unit: bus tasks, frames, interrupts and low-power.
`timescale 1ns/10ps
`include "uflp_cfg.svh"
module test_uflp_top;
  localparam logic [7:0] c1 = `UFLP_OFS_CTRL1, c2 = `UFLP_OFS_CTRL2, st = `UFLP_OFS_STATUS;
  localparam logic [7:0] dv = `UFLP_OFS_BAUD_DIV, rb = `UFLP_OFS_RX_BUF, tb = `UFLP_OFS_TX_BUF;
  localparam logic [7:0] is = `UFLP_OFS_IRQ_STAT, im = `UFLP_OFS_IRQ_MASK;
  logic        core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, stop_mode = 1'b0;
  logic        idle_lowpower_mode = 1'b0, sleep_lowpower_mode = 1'b0, sys_out_en = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, serial_in_pin, serial_out_pin, serial_out_oe_n, irq;
  int          n_fail = 0, cmp_count = 0;

  uflp_top i_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .stop_mode, .idle_lowpower_mode,
    .sleep_lowpower_mode, .sys_out_en, .brg_ext_tick(1'b0), .serial_in_pin,
    .serial_out_pin, .serial_out_oe_n, .irq);
  uflp_remote_model i_peer (.core_clk, .serial_out_pin, .serial_in_pin);

  initial forever #50 core_clk = ~core_clk;

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    xfer(1'b0, a, 8'h0, x);
    chk({4'h0, x}, {4'h0, e});
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    static logic [7:0] cfg [3] = '{8'h00, 8'h18, 8'h28};
    static logic [7:0] dat [3] = '{8'ha5, 8'h3c, 8'h81};
    logic [11:0] exp;
    int          n0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wr(c1, 8'h80);
    rdc(c1, 8'h00);
    wr(`UFLP_OFS_POWER, 8'h01);
    wr(c2, 8'h20);
    rdc(c2, 8'h20);
    wr(im, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      wr(c1, cfg[k]);
      wr(c1, cfg[k] | 8'hc0);
      n0 = i_peer.n_frames;
      wr(tb, dat[k]);
      repeat (400) if (i_peer.n_frames == n0) @(posedge core_clk);
      exp = {2'h3, (^dat[k] ^ ~cfg[k][4]) | ~cfg[k][3], dat[k], 1'b0};
      chk(i_peer.frame_q, exp);
    end
    wr(c1, 8'hd4);
    rdc(c1, 8'he8);
    rdc(is, 8'h01);
    chk({11'h0, irq}, 12'h1);
    wr(is, 8'h01);
    rdc(is, 8'h00);
    chk({11'h0, irq}, 12'h0);
    wr(c1, 8'h00);
    wr(c1, 8'hc0);
    i_peer.send_byte(8'h5a);
    repeat (400) if (irq !== 1'b1) @(posedge core_clk);
    rdc(st, 8'h04);
    rdc(rb, 8'h5a);
    wr(im, 8'h00);
    rdc(8'h40, 8'h00);
    chk({11'h0, irq}, 12'h0);
    wr(c1, 8'h00);
    wr(dv, 8'h07);
    wr(c1, 8'h1c);
    wr(c1, 8'hdc);
    wr(tb, 8'h00);
    repeat (12) @(posedge core_clk);
    chk({11'h0, serial_out_pin}, 12'h1);
    idle_lowpower_mode <= 1'b1;
    rdc(c1, 8'h1c);
    rdc(dv, 8'h07);
    rdc(st, 8'h00);
    chk({10'h0, serial_out_pin, serial_out_oe_n}, 12'h0);
    idle_lowpower_mode <= 1'b0;
    wr(c1, 8'h18);
    sleep_lowpower_mode <= 1'b1;
    rdc(c1, 8'h18);
    chk({10'h0, serial_out_pin, serial_out_oe_n}, 12'h2);
    sleep_lowpower_mode <= 1'b0;
    stop_mode <= 1'b1;
    rdc(c2, 8'h20);
    chk({10'h0, serial_out_pin, serial_out_oe_n}, 12'h1);
    sys_out_en <= 1'b1;
    rdc(st, 8'h00);
    chk({10'h0, serial_out_pin, serial_out_oe_n}, 12'h2);
    tally_and_finish();
  end
endmodule // test_uflp_top
